// >>> rtl/wdtc_pkg.sv
// Watchdog timer core: register map, field positions, timing and shared types
package wdtc_pkg;

   // Register byte offsets on the APB bus
   localparam logic [7:0] CFG_OFF       = 8'h00;
   localparam logic [7:0] RSTCTL_OFF    = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFF  = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFF  = 8'h0C;
   localparam logic [7:0] COUNT_OFF     = 8'h10;

   // Field positions in the watchdog configuration word
   localparam int CFG_POST_LSB = 0;
   localparam int CFG_PRE_BIT  = 4;
   localparam int CFG_EN_BIT   = 7;

   // Field positions in the reset control register
   localparam int RC_IDLE_BIT  = 2;
   localparam int RC_SLEEP_BIT = 3;
   localparam int RC_TO_BIT    = 4;
   localparam int RC_SWEN_BIT  = 5;

   // Interrupt status and mask bit positions
   localparam int IRQ_TO_BIT   = 0;
   localparam int IRQ_WAKE_BIT = 1;

   // Values after reset; an erased configuration word reads ones in bits 7 and 4 to 0
   localparam logic [7:0] CFG_RESET    = 8'h9F;
   localparam logic [5:0] RSTCTL_RESET = 6'h00;
   localparam logic [1:0] IRQ_RESET    = 2'h0;

   // Clock rates and nominal base timeouts
   localparam int CLK_FREQ_HZ        = 250000000;
   localparam int LP_OSC_FREQ_HZ     = 32000;
   localparam int BASE_TIMEOUT_5_US  = 1000;
   localparam int BASE_TIMEOUT_7_US  = 4000;
   localparam int OSC_DIV_DEFAULT    = CLK_FREQ_HZ / LP_OSC_FREQ_HZ;
   localparam int PRE5_TICKS         = BASE_TIMEOUT_5_US * LP_OSC_FREQ_HZ / 1000000;
   localparam int PRE7_TICKS         = BASE_TIMEOUT_7_US * LP_OSC_FREQ_HZ / 1000000;
   localparam logic [6:0] PRE5_LAST  = 7'(PRE5_TICKS - 1);
   localparam logic [6:0] PRE7_LAST  = 7'(PRE7_TICKS - 1);

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_IDLE} wdtc_pm_t;

   // Events from the processor core, all on pclk
   typedef struct packed {
      logic clear_instr;
      logic power_save;
      logic save_idle;
      logic clk_switch_done;
      logic ext_wake;
   } wdtc_cpu_t;

   // Last postscaler count for a ratio of 2**sel
   function automatic logic [14:0] post_last(input logic [3:0] sel);
      post_last = 15'((16'h0001 << sel) - 16'h0001);
   endfunction

endpackage

// >>> rtl/wdtc_core.sv
// Watchdog timer core with APB register access and interrupt output
// Functional notes
// - Low-power oscillator clocks counter; enable starts it
// - Config bit 4 selects 5-bit or 7-bit prescaler
// - Base timeout 1 ms or 4 ms
// - Four-bit field picks sixteen postscaler ratios
// - Completed clock switch clears all counts
// - Power-save instruction clears all counts
// - Leaving sleep or idle clears counts
// - Clear instruction in run clears counts
// - Watchdog keeps counting in sleep and idle
// - Timeout in sleep/idle wakes, no reset
// - Config enable bit forces watchdog on
// - Otherwise software enable bit 5 gates watchdog
// - Software enable cleared on every reset
// - Timeout flag sticky until software clears
`timescale 1ns/1ps
module wdtc_core #(
   parameter int OSC_DIV = wdtc_pkg::OSC_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Processor core events
   input  wire wdtc_pkg::wdtc_cpu_t cpu_evt,
   // Outputs to the system
   output logic                   low_power_rc_osc_en,
   output logic                   wdt_reset_req,
   output logic                   wake_out,
   output logic                   irq
);

   // Registers
   logic [7:0]          cfg_r;
   logic [5:0]          rc_r;
   logic [1:0]          stat_r;
   logic [1:0]          mask_r;
   logic [15:0]         div_r;
   logic [6:0]          pre_r;
   logic [14:0]         post_r;
   wdtc_pkg::wdtc_pm_t  pm_r;
   logic [31:0]         prdata_r;
   logic                reset_req_r;
   logic                wake_r;

   // Next values
   logic [7:0]          cfg_nxt;
   logic [5:0]          rc_nxt;
   logic [1:0]          stat_nxt;
   logic [1:0]          mask_nxt;
   logic [15:0]         div_nxt;
   logic [6:0]          pre_nxt;
   logic [14:0]         post_nxt;
   wdtc_pkg::wdtc_pm_t  pm_nxt;
   logic [31:0]         rd_mux;

   // APB decode
   wire         setup      = psel & ~penable;
   wire         access     = psel & penable;
   wire         hit_cfg    = paddr == wdtc_pkg::CFG_OFF;
   wire         hit_rc     = paddr == wdtc_pkg::RSTCTL_OFF;
   wire         hit_stat   = paddr == wdtc_pkg::IRQ_STAT_OFF;
   wire         hit_mask   = paddr == wdtc_pkg::IRQ_MASK_OFF;
   wire         hit_count  = paddr == wdtc_pkg::COUNT_OFF;
   wire         mapped     = hit_cfg | hit_rc | hit_stat | hit_mask | hit_count;
   wire         wr         = access & pwrite & mapped;
   wire         wr_cfg     = wr & hit_cfg;
   wire         wr_rc      = wr & hit_rc;
   wire         wr_stat    = wr & hit_stat;
   wire         wr_mask    = wr & hit_mask;

   // Enable and power mode
   wire         cfg_en     = cfg_r[wdtc_pkg::CFG_EN_BIT];
   wire         sw_en      = rc_r[wdtc_pkg::RC_SWEN_BIT];
   wire         wdt_en     = cfg_en | sw_en;
   wire         run        = pm_r == wdtc_pkg::PM_RUN;
   wire         pre_sel    = cfg_r[wdtc_pkg::CFG_PRE_BIT];
   wire [3:0]   post_sel   = cfg_r[wdtc_pkg::CFG_POST_LSB +: 4];

   // Oscillator tick, prescaler and postscaler terminal counts
   wire         tick       = wdt_en & (div_r == 16'(OSC_DIV - 1));
   wire [6:0]   pre_last   = pre_sel ? wdtc_pkg::PRE7_LAST
                                     : wdtc_pkg::PRE5_LAST;
   wire         pre_pulse  = tick & (pre_r == pre_last);
   wire [14:0]  post_end   = wdtc_pkg::post_last(post_sel);
   wire         post_done  = pre_pulse & (post_r == post_end);

   // Clearing events; a clear in the same cycle beats a terminal count
   wire         enter_ps   = run & cpu_evt.power_save;
   wire         clr_instr  = run & cpu_evt.clear_instr;
   wire         timeout    = post_done & ~clr_instr & ~enter_ps
                             & ~cpu_evt.clk_switch_done;
   wire         wake       = ~run & (timeout | cpu_evt.ext_wake);
   wire         clr_any    = clr_instr | enter_ps | wake
                             | cpu_evt.clk_switch_done | ~wdt_en;

   // Counter next values; counting does not depend on power mode
   assign div_nxt  = (~wdt_en | tick) ? 16'h0000 : div_r + 16'h0001;
   assign pre_nxt  = clr_any   ? 7'h00 :
                     pre_pulse ? 7'h00 :
                     tick      ? pre_r + 7'h01 : pre_r;
   assign post_nxt = clr_any   ? 15'h0000 :
                     post_done ? 15'h0000 :
                     pre_pulse ? post_r + 15'h0001 : post_r;

   // Power mode sequencing
   always_comb begin
      pm_nxt = pm_r;
      unique case (pm_r)
         wdtc_pkg::PM_RUN: begin
            if (cpu_evt.power_save) begin
               pm_nxt = cpu_evt.save_idle ? wdtc_pkg::PM_IDLE : wdtc_pkg::PM_SLEEP;
            end
         end
         wdtc_pkg::PM_SLEEP, wdtc_pkg::PM_IDLE: begin
            if (wake) begin
               pm_nxt = wdtc_pkg::PM_RUN;
            end
         end
         default: begin
            pm_nxt = wdtc_pkg::PM_RUN;
         end
      endcase
   end

   // Reset control: hardware sets win over software writes
   wire         set_to     = timeout;
   wire         set_sleep  = enter_ps & ~cpu_evt.save_idle;
   wire         set_idle   = enter_ps & cpu_evt.save_idle;
   wire [5:0]   rc_wr      = wr_rc ? pwdata[5:0] : rc_r;
   assign rc_nxt = {rc_wr[wdtc_pkg::RC_SWEN_BIT],
                    rc_wr[wdtc_pkg::RC_TO_BIT]    | set_to,
                    rc_wr[wdtc_pkg::RC_SLEEP_BIT] | set_sleep,
                    rc_wr[wdtc_pkg::RC_IDLE_BIT]  | set_idle,
                    2'b00};
   assign cfg_nxt  = wr_cfg ? pwdata[7:0] : cfg_r;

   // Interrupt status, write one to clear, set wins
   wire [1:0]   stat_set   = {wake, timeout};
   wire [1:0]   stat_clr   = wr_stat ? pwdata[1:0] : 2'b00;
   assign stat_nxt = stat_set | (stat_r & ~stat_clr);
   assign mask_nxt = wr_mask ? pwdata[1:0] : mask_r;

   // Read data, captured in the setup cycle
   assign rd_mux = hit_cfg   ? {24'h000000, cfg_r} :
                   hit_rc    ? {26'h0000000, rc_r} :
                   hit_stat  ? {30'h00000000, stat_r} :
                   hit_mask  ? {30'h00000000, mask_r} :
                   hit_count ? {6'h00, pm_r, 1'b0, pre_r, 1'b0, post_r} :
                               32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r  <= wdtc_pkg::CFG_RESET;
         rc_r   <= wdtc_pkg::RSTCTL_RESET;
         stat_r <= wdtc_pkg::IRQ_RESET;
         mask_r <= wdtc_pkg::IRQ_RESET;
         pm_r   <= wdtc_pkg::PM_RUN;
      end else begin
         cfg_r  <= cfg_nxt;
         rc_r   <= rc_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         pm_r   <= pm_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r  <= 16'h0000;
         pre_r  <= 7'h00;
         post_r <= 15'h0000;
      end else begin
         div_r  <= div_nxt;
         pre_r  <= pre_nxt;
         post_r <= post_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r    <= 32'h00000000;
         reset_req_r <= 1'b0;
         wake_r      <= 1'b0;
      end else begin
         prdata_r    <= setup ? rd_mux : prdata_r;
         reset_req_r <= timeout & run;
         wake_r      <= wake;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = 1'b1;
   assign pslverr       = access & ~mapped;
   assign low_power_rc_osc_en = wdt_en;
   assign wdt_reset_req = reset_req_r;
   assign wake_out      = wake_r;
   assign irq           = |(stat_r & mask_r);

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_osc_on_enable: assert property (
      (cfg_en | sw_en) |-> low_power_rc_osc_en) else $error("oscillator off while enabled");
   a_pre5_wrap: assert property (
      (tick & ~pre_sel & pre_r == 7'h1F & ~clr_any) |=> pre_r == 7'h00)
      else $error("5-bit prescaler did not wrap at 32");
   a_pre7_hold: assert property (
      (tick & pre_sel & pre_r == 7'h1F & ~clr_any) |=> pre_r == 7'h20)
      else $error("7-bit prescaler wrapped early");
   a_post_step: assert property (
      (pre_pulse & ~clr_any & post_r != post_end) |=> post_r == $past(post_r) + 15'h0001)
      else $error("postscaler did not advance");
   a_clk_sw_clear: assert property (
      cpu_evt.clk_switch_done |=> (pre_r == 7'h00 && post_r == 15'h0000))
      else $error("clock switch left counts");
   a_ps_entry: assert property (
      enter_ps |=> (pre_r == 7'h00 && post_r == 15'h0000 && pm_r != wdtc_pkg::PM_RUN))
      else $error("power-save entry wrong");
   a_exit_clear: assert property (
      wake |=> (pre_r == 7'h00 && post_r == 15'h0000 && pm_r == wdtc_pkg::PM_RUN))
      else $error("exit did not clear counts");
   a_clr_instr: assert property (
      clr_instr |=> (pre_r == 7'h00 && post_r == 15'h0000))
      else $error("clear instruction ignored");
   a_sleep_count: assert property (
      (~run & tick & ~clr_any & pre_r != pre_last) |=> pre_r == $past(pre_r) + 7'h01)
      else $error("no counting in power save");
   a_wake_no_reset: assert property (
      (~run & timeout) |=> (wake_out && !wdt_reset_req) ##1 pm_r == wdtc_pkg::PM_RUN)
      else $error("timeout in power save misbehaved");
   a_sw_disable: assert property (
      (~cfg_en & ~sw_en) |-> (!low_power_rc_osc_en ##1 (pre_r == 7'h00 && post_r == 15'h0000)))
      else $error("watchdog ran while disabled");
   a_cfg_force: assert property (
      (cfg_en & ~sw_en & tick & ~clr_any & ~pre_pulse) |=> pre_r != 7'h00)
      else $error("config enable not honoured");
   a_flag_sticky: assert property (
      timeout |=> rc_r[wdtc_pkg::RC_TO_BIT] ##1 (rc_r[wdtc_pkg::RC_TO_BIT] | $past(wr_rc)))
      else $error("timeout flag lost");
   a_run_reset: assert property (
      (run & timeout) |=> (wdt_reset_req && !wake_out))
      else $error("run timeout gave no reset");

   c_run_timeout:   cover property (run & timeout);
   c_sleep_wake:    cover property ((pm_r == wdtc_pkg::PM_SLEEP) & timeout);
   c_idle_wake:     cover property ((pm_r == wdtc_pkg::PM_IDLE) & wake);
   c_irq_raised:    cover property ($rose(irq));

endmodule // wdtc_core

// >>> verification/tb_watchdog_timer_core.sv
// Self-checking testbench for the watchdog timer core over APB and core events
`timescale 1ns/1ps
module tb_watchdog_timer_core;
   // Small divider keeps each tested timeout within a few thousand cycles
   localparam int DIV = 4;
   logic                 pclk = 1'b0;
   logic                 presetn = 1'b0;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic [31:0]          rd;
   logic                 pready, pslverr, err, low_power_rc_osc_en, wdt_reset_req, wake_out, irq;
   wdtc_pkg::wdtc_cpu_t  cpu_evt = '0;
   int                   mismatches = 0;
   int                   total_checks = 0;
   int                   rst_seen = 0;
   int                   wake_seen = 0;

   wdtc_core #(.OSC_DIV(DIV)) i_wdtc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_evt(cpu_evt),
      .low_power_rc_osc_en(low_power_rc_osc_en),
      .wdt_reset_req(wdt_reset_req), .wake_out(wake_out), .irq(irq));

   always #2 pclk = ~pclk;

   always @(posedge pclk) begin
      if (wdt_reset_req === 1'b1) rst_seen++;
      if (wake_out === 1'b1) wake_seen++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int exp);
      total_checks++;
      if (got < exp - 12 || got > exp + 12) begin
         mismatches++;
         $display("MISMATCH t=%0t period %0d exp %0d", $time, got, exp);
      end
   endtask

   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog process ends a wait that never completes
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic pulse(input wdtc_pkg::wdtc_cpu_t e);
      @(posedge pclk);
      cpu_evt <= e;
      @(posedge pclk);
      cpu_evt <= '0;
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   // Restart with config enable set, write cfg, then software enable and time the reset request
   task automatic tmo(input logic [7:0] cfg, input int exp);
      int n;
      do_reset();
      apb(1'b1, wdtc_pkg::CFG_OFF, {24'h0, cfg});
      apb(1'b1, wdtc_pkg::RSTCTL_OFF, 32'h20);
      n = 0;
      while (wdt_reset_req !== 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      chk_rng(n, exp);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #240000;
      mismatches++;
      test_done();
   end

   initial begin
      wdtc_pkg::wdtc_cpu_t e;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(wdtc_pkg::CFG_OFF, 32'h9F);
      rdchk(wdtc_pkg::RSTCTL_OFF, 32'h0);
      chk(low_power_rc_osc_en, 1'b1);
      rdchk(8'h14, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, wdtc_pkg::CFG_OFF, 32'h0);
      repeat (300) @(posedge pclk);
      chk(low_power_rc_osc_en, 1'b0);
      chk(rst_seen, 0);
      $display("test reset_and_enable done");
      tmo(8'h00, 128);
      tmo(8'h01, 256);
      tmo(8'h03, 1024);
      tmo(8'h10, 512);
      tmo(8'h80, 128);
      $display("test periods done");
      for (int k = 0; k < 2; k++) begin
         do_reset();
         apb(1'b1, wdtc_pkg::CFG_OFF, 32'h0);
         apb(1'b1, wdtc_pkg::RSTCTL_OFF, 32'h20);
         rst_seen = 0;
         e = '0;
         e.clear_instr = (k == 0);
         e.clk_switch_done = (k == 1);
         repeat (6) begin
            repeat (100) @(posedge pclk);
            pulse(e);
         end
         chk(rst_seen, 0);
         repeat (200) @(posedge pclk);
         chk(rst_seen, 1);
      end
      do_reset();
      rdchk(wdtc_pkg::RSTCTL_OFF, 32'h0);
      $display("test clears done");
      for (int m = 0; m < 2; m++) begin
         do_reset();
         apb(1'b1, wdtc_pkg::CFG_OFF, 32'h0);
         apb(1'b1, wdtc_pkg::RSTCTL_OFF, 32'h20);
         repeat (60) @(posedge pclk);
         rst_seen = 0;
         wake_seen = 0;
         e = '0;
         e.power_save = 1'b1;
         e.save_idle = m[0];
         pulse(e);
         repeat (50) @(posedge pclk);
         apb(1'b0, wdtc_pkg::COUNT_OFF, 32'h0);
         chk({30'h0, rd[25:24]}, m + 1);
         chk(rd[22:16] != 7'h00, 1'b1);
         repeat (150) @(posedge pclk);
         chk(wake_seen, 1);
         chk(rst_seen, 0);
         rdchk(wdtc_pkg::RSTCTL_OFF, m ? 32'h34 : 32'h38);
         rdchk(wdtc_pkg::IRQ_STAT_OFF, 32'h3);
         chk(irq, 1'b0);
         apb(1'b1, wdtc_pkg::IRQ_MASK_OFF, 32'h3);
         @(posedge pclk);
         chk(irq, 1'b1);
         apb(1'b1, wdtc_pkg::IRQ_STAT_OFF, 32'h1);
         @(posedge pclk);
         chk(irq, 1'b1);
         apb(1'b1, wdtc_pkg::IRQ_STAT_OFF, 32'h2);
         @(posedge pclk);
         chk(irq, 1'b0);
         apb(1'b0, wdtc_pkg::COUNT_OFF, 32'h0);
         chk({30'h0, rd[25:24]}, 32'h0);
         apb(1'b1, wdtc_pkg::RSTCTL_OFF, 32'h20);
         rdchk(wdtc_pkg::RSTCTL_OFF, 32'h20);
      end
      $display("test sleep_idle done");
      test_done();
   end
endmodule // tb_watchdog_timer_core
